// File: src/eac_pkg.sv
/*
   eac_pkg: constants shared by both ends of the nvm access control block.
   assumes one 20 MHz system clock at both ends.
*/
package eac_pkg;
   // ***************************************************
   // io map of the device end
   // ***************************************************
   localparam logic [5:0] IO_SCR0 = 6'h1E;
   localparam logic [5:0] IO_CTRL = 6'h1F;
   localparam logic [5:0] IO_DATA = 6'h20;
   localparam logic [5:0] IO_ADLO = 6'h21;
   localparam logic [5:0] IO_ADHI = 6'h22;
   localparam logic [5:0] IO_SCR1 = 6'h2A;
   localparam logic [5:0] IO_SCR2 = 6'h2B;
   // nvm_control_reg bit positions
   localparam int CB_READ = 0;
   localparam int CB_PROG = 1;
   localparam int CB_MPE = 2;
   localparam int CB_RIE = 3;
   localparam int CB_MODE = 4;
   localparam int ADDR_W = 12;
   localparam int EE_AW = 10;
   localparam int EE_DEPTH = 1 << EE_AW;
   localparam logic [7:0] ERASED = 8'hFF;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   // ***************************************************
   // timing
   // ***************************************************
   localparam logic [2:0] MPE_WIN_CYC = 3'h4;
   localparam logic [2:0] PROG_STALL_CYC = 3'h2;
   localparam logic [2:0] READ_STALL_CYC = 3'h4;
   localparam int PROG_CNT_W = 15;
   localparam int PROG_ATOMIC_RC = 26368;
   localparam int PROG_ATOMIC_US = 3400;
   localparam int PROG_SPLIT_US = 1800;
   localparam int PROG_SPLIT_RC = (PROG_ATOMIC_RC * PROG_SPLIT_US + PROG_ATOMIC_US - 1) / PROG_ATOMIC_US;
   typedef enum logic [1:0] {
      PM_ATOMIC = 2'b00,
      PM_ERASE = 2'b01,
      PM_WRITE = 2'b10,
      PM_RSVD = 2'b11
   } eac_mode_e;
   // ***************************************************
   // wishbone map of the core end
   // ***************************************************
   localparam logic [7:0] HR_CMD = 8'h00;
   localparam logic [7:0] HR_ADDR = 8'h04;
   localparam logic [7:0] HR_WDATA = 8'h08;
   localparam logic [7:0] HR_RDATA = 8'h0C;
   localparam logic [7:0] HR_STATUS = 8'h10;
   localparam logic [7:0] HR_ISTAT = 8'h14;
   localparam logic [7:0] HR_IMASK = 8'h18;
   localparam logic [7:0] HR_CFG = 8'h1C;
   localparam int HC_WRITE = 0;
   localparam int HC_READ = 1;
   localparam int HC_IOWR = 2;
   localparam int HC_IORD = 3;
   localparam int IS_DONE = 0;
   localparam int IS_READY = 1;
   localparam int CFG_RIE = 2;
endpackage

// File: src/eac_io_if.sv
/*
   eac_io_if: io register port between the core end and the device end.
   assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface eac_io_if;
   logic [5:0] io_addr;
   logic io_wr;
   logic io_rd;
   logic [7:0] io_wdata;
   logic [7:0] io_rdata;
   logic stall;
   logic ready_irq;
   logic global_ie;
   logic spm_busy;
   modport dev (
      input io_addr, io_wr, io_rd, io_wdata, global_ie, spm_busy,
      output io_rdata, stall, ready_irq
   );
   modport core (
      output io_addr, io_wr, io_rd, io_wdata, global_ie, spm_busy,
      input io_rdata, stall, ready_irq
   );
endinterface
`default_nettype wire

// File: src/eac_dev.sv
/*
   eac_dev: device end, nvm control, address, data and scratch registers
   with a byte array as the nonvolatile store.
   assumes the core end drives the io port on sys_clk_i and holds off
   while stall is high; rc_osc_i is the calibrated oscillator, asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module eac_dev #(
   parameter int PROG_ATOMIC_RC_CYC = eac_pkg::PROG_ATOMIC_RC,
   parameter int PROG_SPLIT_RC_CYC = eac_pkg::PROG_SPLIT_RC
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic rc_osc_i,
   output logic prog_busy_o,
   eac_io_if.dev io
);
   import eac_pkg::*;

   // ***************************************************
   // state
   // ***************************************************
   typedef struct packed {
      logic [7:0] scr0;
      logic [7:0] scr1;
      logic [7:0] scr2;
      logic [7:0] data;
      logic [7:0] wbuf;
      logic [7:0] rdata;
      logic [ADDR_W-1:0] addr;
      eac_mode_e mode;
      eac_mode_e run_mode;
      logic rie;
      logic mpe;
      logic pe;
      logic stall;
      logic irq;
      logic [2:0] mpe_cnt;
      logic [2:0] stall_cnt;
      logic [2:0] osc;
      logic [PROG_CNT_W-1:0] prog_cnt;
   } eac_dev_s;

   eac_dev_s q;
   eac_dev_s n;
   logic [7:0] mem [EE_DEPTH];
   logic mem_we;
   logic [7:0] mem_val;
   logic [7:0] mem_rd;
   logic tick;
   logic strobe_ok;

   // ***************************************************
   // decode helpers
   // ***************************************************
   function automatic logic [PROG_CNT_W-1:0] prog_len(input eac_mode_e m);
      logic [PROG_CNT_W-1:0] len;
      len = PROG_CNT_W'(PROG_SPLIT_RC_CYC);
      if (m == PM_ATOMIC) begin
         len = PROG_CNT_W'(PROG_ATOMIC_RC_CYC);
      end
      return len;
   endfunction

   function automatic logic [7:0] ctrl_image(input eac_dev_s s);
      return {2'b00, s.mode, s.rie, s.mpe, s.pe, 1'b0};
   endfunction

   assign mem_rd = mem[q.addr[EE_AW-1:0]];

   // ***************************************************
   // next state
   // ***************************************************
   always_comb begin
      n = q;
      mem_we = 1'b0;
      mem_val = q.wbuf;
      strobe_ok = 1'b0;
      // osc[0] feeds only osc[1]; edges are taken from osc[2:1]
      n.osc = {q.osc[1:0], rc_osc_i};
      tick = q.osc[1] & ~q.osc[2];

      if (q.mpe_cnt != 3'h0) begin
         n.mpe_cnt = q.mpe_cnt - 3'h1;
         if (q.mpe_cnt == 3'h1) begin
            n.mpe = 1'b0;
         end
      end
      if (q.stall_cnt != 3'h0) begin
         n.stall_cnt = q.stall_cnt - 3'h1;
      end

      // program cycle runs on oscillator edges
      if (q.pe && tick) begin
         n.prog_cnt = q.prog_cnt - PROG_CNT_W'(1);
         if (q.prog_cnt == PROG_CNT_W'(1)) begin
            n.pe = 1'b0;
            mem_we = 1'b1;
         end
      end
      unique case (q.run_mode)
         PM_ATOMIC: mem_val = q.wbuf;
         PM_ERASE: mem_val = ERASED;
         PM_WRITE: mem_val = mem_rd & q.wbuf;
         PM_RSVD: mem_val = mem_rd;
      endcase

      // register writes; nothing is taken while the core is stalled
      if (io.io_wr && !q.stall) begin
         case (io.io_addr)
            IO_SCR0: n.scr0 = io.io_wdata;
            IO_SCR1: n.scr1 = io.io_wdata;
            IO_SCR2: n.scr2 = io.io_wdata;
            IO_DATA: n.data = io.io_wdata;
            IO_ADLO: begin
               if (!q.pe) begin
                  n.addr[7:0] = io.io_wdata;
               end
            end
            IO_ADHI: begin
               if (!q.pe) begin
                  n.addr[ADDR_W-1:8] = io.io_wdata[ADDR_W-9:0];
               end
            end
            IO_CTRL: begin
               n.rie = io.io_wdata[CB_RIE];
               if (!q.pe) begin
                  n.mode = eac_mode_e'(io.io_wdata[CB_MODE+1:CB_MODE]);
               end
               if (io.io_wdata[CB_MPE] && !io.io_wdata[CB_PROG]) begin
                  n.mpe = 1'b1;
                  n.mpe_cnt = MPE_WIN_CYC;
               end
               // strobe counts only inside the enable window
               strobe_ok = io.io_wdata[CB_PROG] && !q.pe && q.mpe
                  && !io.spm_busy && (q.mode != PM_RSVD);
               if (strobe_ok) begin
                  n.pe = 1'b1;
                  n.run_mode = q.mode;
                  n.wbuf = q.data;
                  n.prog_cnt = prog_len(q.mode);
                  n.mpe = 1'b0;
                  n.mpe_cnt = 3'h0;
                  n.stall_cnt = PROG_STALL_CYC;
               end else if (io.io_wdata[CB_READ] && !q.pe) begin
                  n.data = mem_rd;
                  n.stall_cnt = READ_STALL_CYC;
               end
            end
            default: begin
            end
         endcase
      end

      n.stall = (n.stall_cnt != 3'h0);
      n.irq = q.rie && io.global_ie && !q.pe;

      if (io.io_rd) begin
         case (io.io_addr)
            IO_SCR0: n.rdata = q.scr0;
            IO_SCR1: n.rdata = q.scr1;
            IO_SCR2: n.rdata = q.scr2;
            IO_CTRL: n.rdata = ctrl_image(q);
            IO_DATA: n.rdata = q.data;
            IO_ADLO: n.rdata = q.addr[7:0];
            IO_ADHI: n.rdata = {{(16-ADDR_W){1'b0}}, q.addr[ADDR_W-1:8]};
            default: n.rdata = BYTE_ZERO;
         endcase
      end
   end

   // ***************************************************
   // registers
   // ***************************************************
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   // the store itself keeps its contents through reset
   always_ff @(posedge sys_clk_i) begin
      if (mem_we) begin
         mem[q.addr[EE_AW-1:0]] <= mem_val;
      end
   end

   assign io.io_rdata = q.rdata;
   assign io.stall = q.stall;
   assign io.ready_irq = q.irq;
   assign prog_busy_o = q.pe;
endmodule
`default_nettype wire

// File: src/eac_core.sv
/*
   eac_core: core end, runs the byte write and read sequences on the io
   port on orders given over a classic wishbone slave.
   assumes the device end answers io reads in the following cycle.
*/
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module eac_core (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic flash_busy_i,
   output logic irq_o,
   eac_io_if.core io
);
   import eac_pkg::*;

   // ***************************************************
   // state
   // ***************************************************
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00000,
      ST_WPOLL = 5'b00001,
      ST_WPCHK = 5'b00010,
      ST_WADLO = 5'b00011,
      ST_WADHI = 5'b00100,
      ST_WDAT = 5'b00101,
      ST_WMPE = 5'b00110,
      ST_WPE = 5'b00111,
      ST_RPOLL = 5'b01000,
      ST_RPCHK = 5'b01001,
      ST_RADLO = 5'b01010,
      ST_RADHI = 5'b01011,
      ST_RSTRB = 5'b01100,
      ST_RDAT = 5'b01101,
      ST_RGET = 5'b01110,
      ST_RAWW = 5'b01111,
      ST_RAWR = 5'b10000,
      ST_FIN = 5'b10001
   } eac_st_e;

   typedef struct packed {
      eac_st_e st;
      logic [ADDR_W-1:0] addr;
      logic [7:0] wdata;
      logic [7:0] rdata;
      eac_mode_e mode;
      logic rie;
      logic [1:0] stat;
      logic [1:0] mask;
      logic [5:0] io_addr;
      logic [7:0] io_wdata;
      logic io_wr;
      logic io_rd;
      logic gap;
      logic gie;
      logic spm;
      logic ack;
      logic irq;
      logic [31:0] dat;
   } eac_core_s;

   eac_core_s q;
   eac_core_s n;
   logic free;
   logic go_wr;
   logic go_rd;
   logic [5:0] go_a;
   logic [7:0] go_d;
   logic hit;
   logic [1:0] clr;

   function automatic logic wr_hit(input logic h, input logic we, input logic [7:0] a, input logic [7:0] off);
      return h && we && (a == off);
   endfunction

   function automatic logic [7:0] ctl(input eac_core_s s, input logic mpe, input logic pe, input logic rd);
      return {2'b00, s.mode, s.rie, mpe, pe, rd};
   endfunction

   // ***************************************************
   // next state
   // ***************************************************
   always_comb begin
      n = q;
      go_wr = 1'b0;
      go_rd = 1'b0;
      go_a = IO_CTRL;
      go_d = BYTE_ZERO;
      n.io_wr = 1'b0;
      n.io_rd = 1'b0;
      // one quiet cycle after each access lets stall and read data arrive
      n.gap = q.io_wr | q.io_rd;
      free = !q.io_wr && !q.io_rd && !q.gap && !io.stall;
      n.spm = flash_busy_i;

      unique case (q.st)
         ST_IDLE: begin
         end
         ST_WPOLL, ST_RPOLL: begin
            if (free) begin
               go_rd = 1'b1;
               n.st = (q.st == ST_WPOLL) ? ST_WPCHK : ST_RPCHK;
            end
         end
         ST_WPCHK: begin
            if (q.gap) begin
               n.st = (io.io_rdata[CB_PROG] || q.spm) ? ST_WPOLL : ST_WADLO;
            end
         end
         ST_RPCHK: begin
            if (q.gap) begin
               n.st = io.io_rdata[CB_PROG] ? ST_RPOLL : ST_RADLO;
            end
         end
         ST_WADLO, ST_RADLO: begin
            if (free) begin
               go_wr = 1'b1;
               go_a = IO_ADLO;
               go_d = q.addr[7:0];
               n.st = (q.st == ST_WADLO) ? ST_WADHI : ST_RADHI;
            end
         end
         ST_WADHI, ST_RADHI: begin
            if (free) begin
               go_wr = 1'b1;
               go_a = IO_ADHI;
               go_d = {{(16-ADDR_W){1'b0}}, q.addr[ADDR_W-1:8]};
               n.st = (q.st == ST_WADHI) ? ST_WDAT : ST_RSTRB;
            end
         end
         ST_WDAT: begin
            if (free) begin
               go_wr = 1'b1;
               go_a = IO_DATA;
               go_d = q.wdata;
               n.st = ST_WMPE;
            end
         end
         ST_WMPE: begin
            if (free) begin
               go_wr = 1'b1;
               go_d = ctl(q, 1'b1, 1'b0, 1'b0);
               n.st = ST_WPE;
            end
         end
         ST_WPE: begin
            if (free) begin
               go_wr = 1'b1;
               go_d = ctl(q, 1'b1, 1'b1, 1'b0);
               n.st = ST_FIN;
            end
         end
         ST_RSTRB: begin
            if (free) begin
               go_wr = 1'b1;
               go_d = ctl(q, 1'b0, 1'b0, 1'b1);
               n.st = ST_RDAT;
            end
         end
         ST_RDAT: begin
            if (free) begin
               go_rd = 1'b1;
               go_a = IO_DATA;
               n.st = ST_RGET;
            end
         end
         ST_RAWR: begin
            if (free) begin
               go_rd = 1'b1;
               go_a = q.addr[5:0];
               n.st = ST_RGET;
            end
         end
         ST_RGET: begin
            if (q.gap) begin
               n.rdata = io.io_rdata;
               n.st = ST_FIN;
            end
         end
         ST_RAWW: begin
            if (free) begin
               go_wr = 1'b1;
               go_a = q.addr[5:0];
               go_d = q.wdata;
               n.st = ST_FIN;
            end
         end
         ST_FIN: begin
            // done only after the last access, its quiet cycle and any stall
            if (free) begin
               n.st = ST_IDLE;
            end
         end
         default: n.st = ST_IDLE;
      endcase

      if (go_wr || go_rd) begin
         n.io_wr = go_wr;
         n.io_rd = go_rd;
         n.io_addr = go_a;
         n.io_wdata = go_d;
      end

      // ***************************************************
      // wishbone slave, ack one cycle after the request
      // ***************************************************
      hit = wb_cyc_i && wb_stb_i && !q.ack;
      n.ack = hit;
      clr = 2'b00;
      if (wr_hit(hit, wb_we_i, wb_adr_i, HR_CMD) && wb_sel_i[0] && q.st == ST_IDLE) begin
         if (wb_dat_i[HC_WRITE]) begin
            n.st = ST_WPOLL;
         end else if (wb_dat_i[HC_READ]) begin
            n.st = ST_RPOLL;
         end else if (wb_dat_i[HC_IOWR]) begin
            n.st = ST_RAWW;
         end else if (wb_dat_i[HC_IORD]) begin
            n.st = ST_RAWR;
         end
      end
      if (q.st == ST_IDLE) begin
         if (wr_hit(hit, wb_we_i, wb_adr_i, HR_ADDR)) begin
            if (wb_sel_i[0]) begin
               n.addr[7:0] = wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
               n.addr[ADDR_W-1:8] = wb_dat_i[ADDR_W-1:8];
            end
         end
         if (wr_hit(hit, wb_we_i, wb_adr_i, HR_WDATA) && wb_sel_i[0]) begin
            n.wdata = wb_dat_i[7:0];
         end
         if (wr_hit(hit, wb_we_i, wb_adr_i, HR_CFG) && wb_sel_i[0]) begin
            n.mode = eac_mode_e'(wb_dat_i[1:0]);
            n.rie = wb_dat_i[CFG_RIE];
         end
      end
      if (wr_hit(hit, wb_we_i, wb_adr_i, HR_IMASK) && wb_sel_i[0]) begin
         n.mask = wb_dat_i[1:0];
      end
      if (wr_hit(hit, wb_we_i, wb_adr_i, HR_ISTAT) && wb_sel_i[0]) begin
         clr = wb_dat_i[1:0];
      end
      // a new event wins over a clear in the same cycle
      n.stat = (q.stat & ~clr) | {io.ready_irq, q.st == ST_FIN && n.st == ST_IDLE};
      n.irq = |(q.stat & q.mask);
      n.dat = 32'h0000_0000;
      if (hit && !wb_we_i) begin
         case (wb_adr_i)
            HR_ADDR: n.dat = {{(32-ADDR_W){1'b0}}, q.addr};
            HR_WDATA: n.dat = {24'h00_0000, q.wdata};
            HR_RDATA: n.dat = {24'h00_0000, q.rdata};
            HR_STATUS: n.dat = {31'h0000_0000, q.st != ST_IDLE};
            HR_ISTAT: n.dat = {30'h0000_0000, q.stat};
            HR_IMASK: n.dat = {30'h0000_0000, q.mask};
            HR_CFG: n.dat = {29'h0000_0000, q.rie, q.mode};
            default: n.dat = 32'h0000_0000;
         endcase
      end
      // interrupts stay off from the first poll to the end of a sequence
      n.gie = (n.st == ST_IDLE);
   end

   // ***************************************************
   // registers
   // ***************************************************
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign wb_dat_o = q.dat;
   assign wb_ack_o = q.ack;
   assign irq_o = q.irq;
   assign io.io_addr = q.io_addr;
   assign io.io_wr = q.io_wr;
   assign io.io_rd = q.io_rd;
   assign io.io_wdata = q.io_wdata;
   assign io.global_ie = q.gie;
   assign io.spm_busy = q.spm;
endmodule
`default_nettype wire

// File: dv/eac_assertions.sv
/*
   eac_assertions: checks on the io port between the two ends.
   assumes one clock and a synchronous active high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module eac_assertions (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [5:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   input wire logic stall,
   input wire logic ready_irq,
   input wire logic global_ie,
   input wire logic spm_busy
);
   import eac_pkg::*;
   // ****
   // helpers: age of master enable, scratch shadow
   // ****
   logic [2:0] age_q;
   logic [7:0] scr_q [3];
   logic [7:0] exp_q;
   wire logic ctl_wr = io_wr && !stall && io_addr == IO_CTRL;
   wire logic ctl_rd = io_rd && !stall && io_addr == IO_CTRL;
   wire logic is_scr = io_addr == IO_SCR0 || io_addr == IO_SCR1 || io_addr == IO_SCR2;
   wire logic [1:0] sidx = io_addr == IO_SCR0 ? 2'h0 : (io_addr == IO_SCR1 ? 2'h1 : 2'h2);
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         age_q <= 3'h7;
         scr_q <= '{default: 8'h00};
         exp_q <= 8'h00;
      end else begin
         exp_q <= scr_q[sidx];
         if (ctl_wr && io_wdata[CB_MPE]) begin
            age_q <= 3'h0;
         end else if (age_q != 3'h7) begin
            age_q <= age_q + 3'h1;
         end
         if (io_wr && !stall && is_scr) begin
            scr_q[sidx] <= io_wdata;
         end
      end
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   // ****
   // properties
   // ****
   sequence prog_start;
      ctl_wr && io_wdata[CB_PROG] ##1 stall;
   endsequence
   sequence read_start;
      ctl_wr && io_wdata[CB_READ] && !io_wdata[CB_PROG] ##1 stall;
   endsequence
   stall_cause_a: assert property ($rose(stall) |-> $past(ctl_wr))
      else $error("stall rose without a control write");
   prog_stall_a: assert property (prog_start |=> stall ##1 !stall)
      else $error("program stall not two cycles");
   read_stall_a: assert property (read_start |=> stall [*3] ##1 !stall)
      else $error("read stall not four cycles");
   stall_bound_a: assert property ($rose(stall) |-> ##[2:4] !stall)
      else $error("stall held too long");
   enable_window_a: assert property (ctl_wr && io_wdata[CB_PROG] && age_q >= 3'h4 |=> !stall)
      else $error("strobe accepted without fresh master enable");
   flash_lock_a: assert property (ctl_wr && io_wdata[CB_PROG] && spm_busy |=> !stall)
      else $error("strobe accepted during self program");
   enable_clear_a: assert property (ctl_rd && age_q >= 3'h4 |=> !io_rdata[CB_MPE])
      else $error("master enable did not self clear");
   scratch_read_a: assert property (io_rd && !stall && is_scr |=> io_rdata == exp_q)
      else $error("scratch read back wrong");
   ready_gate_a: assert property (ready_irq |-> global_ie || $past(global_ie))
      else $error("ready interrupt without global enable");
endmodule
`default_nettype wire

// File: dv/tb.sv
/*
   tb: drives the core end over wishbone, the device end answers on the io port.
   assumes eac_pkg offsets; program counts shortened by parameters.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
   import eac_pkg::*;
   localparam int RC_A = 8;
   localparam int RC_S = 4;
   logic clk, rst, osc, cyc, stb, we, fbusy, ack, irq, pbusy;
   logic [7:0] adr;
   logic [31:0] wdat, dat_o, q;
   int fail_count, cmp_count, cyc_n, pb_n, lim;
   logic [1:0] md [6] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h0};
   logic [7:0] dt [6] = '{8'h5A, 8'h00, 8'h3C, 8'h0F, 8'hAA, 8'hA5};
   logic [7:0] ex [6] = '{8'h5A, 8'hFF, 8'h3C, 8'h0C, 8'h0C, 8'hA5};
   logic [5:0] sa [3] = '{IO_SCR0, IO_SCR1, IO_SCR2};
   eac_io_if io();
   eac_dev #(.PROG_ATOMIC_RC_CYC(RC_A), .PROG_SPLIT_RC_CYC(RC_S)) i_eac_dev (.sys_clk_i(clk), .rst_i(rst),
      .rc_osc_i(osc), .prog_busy_o(pbusy), .io(io));
   eac_core i_eac_core (.sys_clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .flash_busy_i(fbusy), .irq_o(irq), .io(io));
   eac_assertions i_eac_assertions (.sys_clk_i(clk), .rst_i(rst), .io_addr(io.io_addr), .io_wr(io.io_wr),
      .io_rd(io.io_rd), .io_wdata(io.io_wdata), .io_rdata(io.io_rdata), .stall(io.stall),
      .ready_irq(io.ready_irq), .global_ie(io.global_ie), .spm_busy(io.spm_busy));
   // ****
   // clocks, cycle counters, timeout
   // ****
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      osc = 1'b0;
      #7;
      forever #85 osc = ~osc;
   end
   always @(posedge clk) begin
      cyc_n++;
      if (pbusy === 1'b1) begin
         pb_n++;
      end
      if (cyc_n == 20000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   // ****
   // tasks
   // ****
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_idle;
      do wb(1'b0, HR_STATUS, 32'h0); while (q[0] !== 1'b0);
   endtask
   task automatic nv_write(input logic [7:0] cfg, input logic [7:0] d);
      wb(1'b1, HR_CFG, {24'h0, cfg});
      wb(1'b1, HR_WDATA, {24'h0, d});
      pb_n = 0;
      wb(1'b1, HR_CMD, 32'h1);
      wait_idle();
      // the core goes idle once the strobe is taken; the program runs on
      while (pbusy !== 1'b0) begin
         @(posedge clk);
      end
   endtask
   task automatic nv_read;
      wb(1'b1, HR_CMD, 32'h2);
      wait_idle();
      wb(1'b0, HR_RDATA, 32'h0);
   endtask
   task automatic io_acc(input logic [3:0] cmd, input logic [5:0] a, input logic [7:0] d);
      wb(1'b1, HR_ADDR, {26'h0, a});
      wb(1'b1, HR_WDATA, {24'h0, d});
      wb(1'b1, HR_CMD, {28'h0, cmd});
      wait_idle();
      wb(1'b0, HR_RDATA, 32'h0);
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ****
   // tests
   // ****
   initial begin
      {cyc, stb, we, fbusy} = 4'h0;
      adr = 8'h00;
      wdat = 32'h0;
      rst = 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         io_acc(4'h8, sa[i], 8'h00);
         check(q, 32'h0);
         io_acc(4'h4, sa[i], 8'hA5 ^ 8'(i));
      end
      for (int i = 0; i < 3; i++) begin
         io_acc(4'h8, sa[i], 8'h00);
         check(q, {24'h0, 8'hA5 ^ 8'(i)});
      end
      io_acc(4'h8, 6'h3F, 8'h00);
      check(q, 32'h0);
      wb(1'b1, 8'h40, 32'hFF);
      wb(1'b0, 8'h40, 32'h0);
      check(q, 32'h0);
      $display("test scratch done");
      wb(1'b1, HR_ADDR, 32'h2C5);
      for (int i = 0; i < 6; i++) begin
         nv_write({6'h0, md[i]}, dt[i]);
         lim = md[i] == 2'h3 ? 0 : (md[i] == 2'h0 ? RC_A : RC_S);
         check(pb_n >= (lim - 1) * 170 / 50 && pb_n <= lim * 170 / 50 + 8 * (lim > 0), 1);
         nv_read();
         check(q, {24'h0, ex[i]});
      end
      $display("test modes done");
      // flash turns busy after the core has passed its poll, so the device must refuse
      wb(1'b1, HR_CFG, 32'h0);
      wb(1'b1, HR_WDATA, 32'h77);
      pb_n = 0;
      wb(1'b1, HR_CMD, 32'h1);
      repeat (2) @(posedge clk);
      fbusy <= 1'b1;
      wait_idle();
      check(pb_n, 0);
      fbusy <= 1'b0;
      nv_read();
      check(q, 32'hA5);
      // a strobe long after the enable must be refused
      pb_n = 0;
      io_acc(4'h4, IO_CTRL, 8'h04);
      io_acc(4'h4, IO_CTRL, 8'h06);
      io_acc(4'h8, IO_CTRL, 8'h00);
      check(q, 32'h0);
      check(pb_n, 0);
      $display("test flash lock done");
      wb(1'b1, HR_ISTAT, 32'h3);
      wb(1'b1, HR_IMASK, 32'h1);
      nv_write(8'h00, 8'h11);
      wb(1'b0, HR_ISTAT, 32'h0);
      check(q[0], 1'b1);
      check(irq, 1'b1);
      wb(1'b1, HR_IMASK, 32'h0);
      wb(1'b0, HR_ISTAT, 32'h0);
      check(irq, 1'b0);
      wb(1'b1, HR_IMASK, 32'h2);
      wb(1'b1, HR_ISTAT, 32'h1);
      wb(1'b0, HR_ISTAT, 32'h0);
      check(q[1:0], 2'h0);
      nv_write(8'h04, 8'h22);
      wb(1'b1, HR_ISTAT, 32'h2);
      wb(1'b0, HR_ISTAT, 32'h0);
      check(q[1], 1'b1);
      check(irq, 1'b1);
      nv_write(8'h00, 8'h33);
      wb(1'b1, HR_ISTAT, 32'h3);
      wb(1'b0, HR_ISTAT, 32'h0);
      check(q[1:0], 2'h0);
      check(irq, 1'b0);
      $display("test interrupt done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
